// *** pkg/wolrc_pkg.sv ***
// Constants for the wake-on-network receive configuration block.
// Assumes a single 100 MHz clock and a 16-bit register port with word indices.
package wolrc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port
	localparam int unsigned WOLRC_AW = 9;
	localparam int unsigned WOLRC_DW = 16;

	localparam logic [8:0] WOLRC_CFG_IDX      = 9'h134;
	localparam logic [8:0] WOLRC_FLAGS_IDX    = 9'h135;
	localparam logic [8:0] WOLRC_PWD0_IDX     = 9'h139;
	localparam logic [8:0] WOLRC_PWD1_IDX     = 9'h13a;
	localparam logic [8:0] WOLRC_PWD2_IDX     = 9'h13b;
	localparam logic [8:0] WOLRC_IRQ_STS_IDX  = 9'h1f0;
	localparam logic [8:0] WOLRC_IRQ_MASK_IDX = 9'h1f1;

	////////////////////////////////////////////////////////////////////////////
	// Configuration register fields
	localparam int unsigned WOLRC_CFG_CLR_BIT  = 11;
	localparam int unsigned WOLRC_CFG_STR_LO   = 9;
	localparam int unsigned WOLRC_CFG_MODE_BIT = 8;
	localparam int unsigned WOLRC_CFG_ENH_BIT  = 7;
	localparam int unsigned WOLRC_CFG_PWEN_BIT = 5;
	localparam int unsigned WOLRC_CFG_UC_BIT   = 4;
	localparam int unsigned WOLRC_CFG_BC_BIT   = 2;
	localparam int unsigned WOLRC_CFG_PAT_BIT  = 1;
	localparam int unsigned WOLRC_CFG_MAG_BIT  = 0;
	localparam logic [15:0] WOLRC_CFG_RST      = 16'h0004;
	localparam logic [15:0] WOLRC_CFG_STORE    = 16'h07b7;

	////////////////////////////////////////////////////////////////////////////
	// Flag and interrupt layout (bit 3 is the wake event in the interrupt copy)
	localparam int unsigned WOLRC_FW        = 8;
	localparam int unsigned WOLRC_F_MAGIC   = 0;
	localparam int unsigned WOLRC_F_PAT     = 1;
	localparam int unsigned WOLRC_F_BC      = 2;
	localparam int unsigned WOLRC_F_WAKE    = 3;
	localparam int unsigned WOLRC_F_UC      = 4;
	localparam int unsigned WOLRC_F_HACK    = 5;
	localparam int unsigned WOLRC_F_CRC     = 6;
	localparam int unsigned WOLRC_F_SFD     = 7;
	localparam logic [7:0]  WOLRC_FLAGS_RST = 8'h00;
	localparam logic [7:0]  WOLRC_FLAGS_USE = 8'hf7;

	////////////////////////////////////////////////////////////////////////////
	// Pulse length: 8, 16, 32 or 64 periods of 8 ns, rounded up to clk cycles
	localparam int unsigned WOLRC_CLK_NS     = 10;
	localparam int unsigned WOLRC_PULSE8_NS  = 64;
	localparam int unsigned WOLRC_CNT_W      = 7;
	localparam logic [6:0]  WOLRC_PULSE_CYC0 =
		7'((WOLRC_PULSE8_NS + WOLRC_CLK_NS - 1) / WOLRC_CLK_NS);
	localparam logic [6:0]  WOLRC_PULSE_CYC1 =
		7'((2 * WOLRC_PULSE8_NS + WOLRC_CLK_NS - 1) / WOLRC_CLK_NS);
	localparam logic [6:0]  WOLRC_PULSE_CYC2 =
		7'((4 * WOLRC_PULSE8_NS + WOLRC_CLK_NS - 1) / WOLRC_CLK_NS);
	localparam logic [6:0]  WOLRC_PULSE_CYC3 =
		7'((8 * WOLRC_PULSE8_NS + WOLRC_CLK_NS - 1) / WOLRC_CLK_NS);

	typedef enum logic [1:0] {
		WOLRC_OUT_IDLE,
		WOLRC_OUT_PULSE,
		WOLRC_OUT_LEVEL
	} wolrc_out_e;

endpackage

// *** core/wolrc_classify.sv ***
// Frame classifier: turns one end-of-frame report into flag and wake events.
// Assumes the receive path reports each frame once, with its type bits valid.
`timescale 1ns/10ps
module wolrc_classify
	import wolrc_pkg::*;
(
	// Frame report
	input  wire logic                        frame_done,
	input  wire logic                        frame_magic,
	input  wire logic                        frame_pattern,
	input  wire logic                        frame_bcast,
	input  wire logic                        frame_ucast,
	input  wire logic                        frame_crc_bad,
	input  wire logic                        frame_sfd_err,
	input  wire logic [47:0]                 frame_password,
	// Configuration
	input  wire logic [15:0]                 cfg,
	input  wire logic [47:0]                 password,
	// Events
	output logic      [wolrc_pkg::WOLRC_FW-1:0] flag_set,
	output logic                             wake_hit
);

	////////////////////////////////////////////////////////////////////////////
	wire enh_on   = cfg[WOLRC_CFG_ENH_BIT];
	wire take     = frame_done && enh_on;
	wire good     = take && !frame_crc_bad && !frame_sfd_err;
	wire pw_match = (frame_password == password);
	wire pw_need  = cfg[WOLRC_CFG_PWEN_BIT];
	wire magic_ok = good && frame_magic && (!pw_need || pw_match);
	wire hack     = good && frame_magic && pw_need && !pw_match;

	wire uc_ok  = good && frame_ucast;
	wire bc_ok  = good && frame_bcast;
	wire pat_ok = good && frame_pattern;

	// Flags show what arrived, whatever the wake enables say
	always_comb begin
		flag_set                = '0;
		flag_set[WOLRC_F_MAGIC] = magic_ok;
		flag_set[WOLRC_F_PAT]   = pat_ok;
		flag_set[WOLRC_F_BC]    = bc_ok;
		flag_set[WOLRC_F_UC]    = uc_ok;
		flag_set[WOLRC_F_HACK]  = hack;
		flag_set[WOLRC_F_CRC]   = take && frame_crc_bad;
		flag_set[WOLRC_F_SFD]   = take && frame_sfd_err;
		flag_set[WOLRC_F_WAKE]  = wake_hit;
	end

	assign wake_hit = (uc_ok && cfg[WOLRC_CFG_UC_BIT])
		|| (bc_ok && cfg[WOLRC_CFG_BC_BIT])
		|| (pat_ok && cfg[WOLRC_CFG_PAT_BIT])
		|| (magic_ok && cfg[WOLRC_CFG_MAG_BIT]);

endmodule

// *** core/wolrc_wake_out.sv ***
// Wake output shaper: stretched pulse or held level.
// Assumes wake and clear requests are single-cycle pulses on clk.
`timescale 1ns/10ps
module wolrc_wake_out
	import wolrc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       wake,
	input  wire logic       clear,
	input  wire logic       level_mode,
	input  wire logic [1:0] stretch,
	// Output
	output logic            wake_out
);

	////////////////////////////////////////////////////////////////////////////
	wolrc_out_e                  state_ff;
	wolrc_out_e                  nxt_state;
	logic [WOLRC_CNT_W-1:0]      cnt_ff;
	logic [WOLRC_CNT_W-1:0]      nxt_cnt;
	logic [WOLRC_CNT_W-1:0]      len;

	always_comb begin
		unique case (stretch)
			2'h0: len = WOLRC_PULSE_CYC0;
			2'h1: len = WOLRC_PULSE_CYC1;
			2'h2: len = WOLRC_PULSE_CYC2;
			2'h3: len = WOLRC_PULSE_CYC3;
		endcase
	end

	// A new wake restarts a running pulse so the output never drops early
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		unique case (state_ff)
			WOLRC_OUT_IDLE: begin
				if (wake && level_mode) begin
					nxt_state = WOLRC_OUT_LEVEL;
				end else if (wake) begin
					nxt_state = WOLRC_OUT_PULSE;
					nxt_cnt   = len - 7'h01;
				end
			end
			WOLRC_OUT_PULSE: begin
				if (wake) begin
					nxt_cnt = len - 7'h01;
				end else if (cnt_ff == 7'h00) begin
					nxt_state = WOLRC_OUT_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 7'h01;
				end
			end
			WOLRC_OUT_LEVEL: begin
				if (clear && !wake) begin
					nxt_state = WOLRC_OUT_IDLE;
				end
			end
			// The spare state code falls back to idle rather than lock the output
			default: begin
				nxt_state = WOLRC_OUT_IDLE;
				nxt_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= WOLRC_OUT_IDLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	assign wake_out = (state_ff != WOLRC_OUT_IDLE);

endmodule

// *** core/wolrc_top.sv ***
// Wake-on-network receive configuration: registers, flags, interrupt, wake output.
// Assumes the receive path classifies frames and reports each one at its end.
//
// Functional notes
// - Writing clear drops held level; self-clearing
// - Pulse length 8/16/32/64 from stretch field
// - Mode bit: one level, zero pulse
// - Detection only while enhanced receive enabled
// - Password enable requires password with magic
// - Unicast enable allows unicast wake
// - Broadcast enable, default on, allows broadcast wake
// - Pattern enable allows pattern match wake
// - Magic enable allows magic packet wake
// - Per-type flags latch, clear when read
// - Password is 48 bits, three registers
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module wolrc_top
	import wolrc_pkg::*;
(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// Register port
	input  wire logic [wolrc_pkg::WOLRC_AW-1:0] reg_addr,
	input  wire logic [wolrc_pkg::WOLRC_DW-1:0] reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [wolrc_pkg::WOLRC_DW-1:0] reg_rdata,
	// Frame report from the receive path
	input  wire logic                           frame_done,
	input  wire logic                           frame_magic,
	input  wire logic                           frame_pattern,
	input  wire logic                           frame_bcast,
	input  wire logic                           frame_ucast,
	input  wire logic                           frame_crc_bad,
	input  wire logic                           frame_sfd_err,
	input  wire logic [47:0]                    frame_password,
	// Outputs
	output logic                                wake_on_network,
	output logic                                irq
);

	import wolrc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	wire hit_cfg  = (reg_addr == WOLRC_CFG_IDX);
	wire hit_flg  = (reg_addr == WOLRC_FLAGS_IDX);
	wire hit_pw0  = (reg_addr == WOLRC_PWD0_IDX);
	wire hit_pw1  = (reg_addr == WOLRC_PWD1_IDX);
	wire hit_pw2  = (reg_addr == WOLRC_PWD2_IDX);
	wire hit_sts  = (reg_addr == WOLRC_IRQ_STS_IDX);
	wire hit_msk  = (reg_addr == WOLRC_IRQ_MASK_IDX);

	wire wr_cfg   = reg_wr && hit_cfg;
	wire wr_pw0   = reg_wr && hit_pw0;
	wire wr_pw1   = reg_wr && hit_pw1;
	wire wr_pw2   = reg_wr && hit_pw2;
	wire wr_sts   = reg_wr && hit_sts;
	wire wr_msk   = reg_wr && hit_msk;
	wire rd_flg   = reg_rd && hit_flg;

	////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [15:0]          cfg_ff;
	logic [15:0]          nxt_cfg;
	logic                 clr_ff;
	logic [15:0]          pw0_ff;
	logic [15:0]          pw1_ff;
	logic [15:0]          pw2_ff;
	logic [WOLRC_FW-1:0]  flags_ff;
	logic [WOLRC_FW-1:0]  nxt_flags;
	logic [WOLRC_FW-1:0]  sts_ff;
	logic [WOLRC_FW-1:0]  nxt_sts;
	logic [WOLRC_FW-1:0]  msk_ff;
	logic [15:0]          rdata_ff;
	logic [15:0]          nxt_rdata;

	wire  [47:0]          password = {pw2_ff, pw1_ff, pw0_ff};
	wire  [WOLRC_FW-1:0]  flag_set;
	wire                  wake_hit;

	// Clear bit is not stored; it acts once and reads back as one only when read in the cycle after its write
	assign nxt_cfg = wr_cfg ? (reg_wdata & WOLRC_CFG_STORE) : cfg_ff;
	wire   clr_req = wr_cfg && reg_wdata[WOLRC_CFG_CLR_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Configuration and password registers

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= WOLRC_CFG_RST;
			clr_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			clr_ff <= clr_req;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pw0_ff <= 16'h0000;
			pw1_ff <= 16'h0000;
			pw2_ff <= 16'h0000;
		end else begin
			pw0_ff <= wr_pw0 ? reg_wdata : pw0_ff;
			pw1_ff <= wr_pw1 ? reg_wdata : pw1_ff;
			pw2_ff <= wr_pw2 ? reg_wdata : pw2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame classification

	wolrc_classify u_classify (
		.frame_done     (frame_done),
		.frame_magic    (frame_magic),
		.frame_pattern  (frame_pattern),
		.frame_bcast    (frame_bcast),
		.frame_ucast    (frame_ucast),
		.frame_crc_bad  (frame_crc_bad),
		.frame_sfd_err  (frame_sfd_err),
		.frame_password (frame_password),
		.cfg            (cfg_ff),
		.password       (password),
		.flag_set       (flag_set),
		.wake_hit       (wake_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Received flags: cleared by the read, but a new event in that cycle wins

	assign nxt_flags = ((rd_flg ? '0 : flags_ff) | flag_set)
		& WOLRC_FLAGS_USE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_ff <= WOLRC_FLAGS_RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear, set wins

	assign nxt_sts = (sts_ff & ~(wr_sts ? reg_wdata[WOLRC_FW-1:0] : '0)) | flag_set;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sts_ff <= '0;
			msk_ff <= '0;
		end else begin
			sts_ff <= nxt_sts;
			msk_ff <= wr_msk ? reg_wdata[WOLRC_FW-1:0] : msk_ff;
		end
	end

	assign irq = |(sts_ff & msk_ff);

	////////////////////////////////////////////////////////////////////////////
	// Wake output

	wolrc_wake_out u_wake_out (
		.clk        (clk),
		.rst        (rst),
		.wake       (wake_hit),
		.clear      (clr_ff),
		.level_mode (cfg_ff[WOLRC_CFG_MODE_BIT]),
		.stretch    (cfg_ff[WOLRC_CFG_STR_LO +: 2]),
		.wake_out   (wake_on_network)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe, zero elsewhere

	wire [15:0] cfg_view = cfg_ff | (16'(clr_ff) << WOLRC_CFG_CLR_BIT);

	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_rd) begin
			unique case (1'b1)
				hit_cfg: nxt_rdata = cfg_view;
				hit_flg: nxt_rdata = {8'h00, flags_ff};
				hit_pw0: nxt_rdata = pw0_ff;
				hit_pw1: nxt_rdata = pw1_ff;
				hit_pw2: nxt_rdata = pw2_ff;
				hit_sts: nxt_rdata = {8'h00, sts_ff};
				hit_msk: nxt_rdata = {8'h00, msk_ff};
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule

// *** sim/wolrc_chk.sv ***
// Checker for the wake-on-network receive configuration block.
// Assumes it is bound to wolrc_top and sees only that module's ports.
`timescale 1ns/10ps
module wolrc_chk
	import wolrc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register port
	input wire logic [8:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Frame report
	input wire logic        frame_done,
	input wire logic        frame_magic,
	input wire logic        frame_pattern,
	input wire logic        frame_bcast,
	input wire logic        frame_ucast,
	input wire logic        frame_crc_bad,
	input wire logic        frame_sfd_err,
	// Wake output
	input wire logic        wake_on_network
);
////////////////////////////////////////////////////////////////////////////////
	logic [15:0] cfg_ff;
	logic [6:0]  run_ff;
	logic [6:0]  plen;
	wire wr_cfg  = reg_wr && reg_addr == WOLRC_CFG_IDX;
	wire clr_now = wr_cfg && reg_wdata[11];
	wire rd_flag = reg_rd && reg_addr == WOLRC_FLAGS_IDX;
	assign plen = cfg_ff[10:9] == 2'h0 ? WOLRC_PULSE_CYC0 :
		cfg_ff[10:9] == 2'h1 ? WOLRC_PULSE_CYC1 :
		cfg_ff[10:9] == 2'h2 ? WOLRC_PULSE_CYC2 : WOLRC_PULSE_CYC3;

	// Run counts cycles since the last frame report; a pulse must end at its length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= 16'h0004;
			run_ff <= 7'h00;
		end else begin
			if (wr_cfg)
				cfg_ff <= reg_wdata & WOLRC_CFG_STORE;
			if (frame_done)
				run_ff <= 7'h01;
			else if (run_ff != 7'h7f)
				run_ff <= run_ff + 7'h01;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_hit(logic c);
		frame_done && cfg_ff[7] && c && !frame_crc_bad && !frame_sfd_err |=> wake_on_network;
	endproperty

	a_ucast_wake: assert property (p_hit(cfg_ff[4] && frame_ucast))
		else $error("unicast frame gave no wake");
	a_bcast_wake: assert property (p_hit(cfg_ff[2] && frame_bcast))
		else $error("broadcast frame gave no wake");
	a_pat_wake: assert property (p_hit(cfg_ff[1] && frame_pattern))
		else $error("pattern frame gave no wake");
	a_magic_wake: assert property (p_hit(cfg_ff[0] && !cfg_ff[5] && frame_magic))
		else $error("magic frame gave no wake");
	a_enh_off: assert property (frame_done && !cfg_ff[7] && !wake_on_network |=> !wake_on_network)
		else $error("wake while enhanced receive off");
	a_pulse_max: assert property (!cfg_ff[8] && wake_on_network |-> run_ff <= plen)
		else $error("wake pulse too long");
	a_pulse_len: assert property (!cfg_ff[8] && $fell(wake_on_network) |-> $past(run_ff) == plen)
		else $error("wake pulse length wrong");
	a_level_hold: assert property (cfg_ff[8] && wake_on_network && !wr_cfg && !$past(wr_cfg)
		&& !$past(wr_cfg, 2) |=> wake_on_network) else $error("level wake dropped");
	a_level_clear: assert property (cfg_ff[8] && clr_now && reg_wdata[8] && !frame_done
		##1 !frame_done ##1 !frame_done |=> !wake_on_network) else $error("level wake not cleared");
	a_cfg_read: assert property (reg_rd && reg_addr == WOLRC_CFG_IDX |=>
		reg_rdata == (cfg_ff | {4'h0, $past(clr_now, 2), 11'h000})) else $error("config read wrong");
	a_flag_clear: assert property (rd_flag && !frame_done ##1 rd_flag |=> reg_rdata == 16'h0000)
		else $error("flags not cleared by read");

	c_pulse: cover property (!cfg_ff[8] && $fell(wake_on_network));
	c_clear: cover property (cfg_ff[8] && clr_now && wake_on_network);
	c_flag2: cover property (rd_flag ##1 rd_flag);
endmodule

// *** sim/wolrc_station.sv ***
// Remote station model: turns a bench request into one frame report.
// Assumes the bench raises req for one cycle per frame.
`timescale 1ns/10ps
module wolrc_station (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Bench request: type bits in flag layout
	input wire logic        req,
	input wire logic [7:0]  req_ty,
	input wire logic [47:0] req_pw,
	// Frame report
	output logic            frame_done,
	output logic            frame_magic,
	output logic            frame_pattern,
	output logic            frame_bcast,
	output logic            frame_ucast,
	output logic            frame_crc_bad,
	output logic            frame_sfd_err,
	output logic     [47:0] frame_password
);
	logic [7:0] ty_ff;
	// Outside a report the type and password lines toggle, so stale values never look valid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_done     <= 1'b0;
			ty_ff          <= 8'h00;
			frame_password <= 48'h0;
		end else begin
			frame_done     <= req;
			ty_ff          <= req ? req_ty : ~ty_ff;
			frame_password <= req ? req_pw : ~frame_password;
		end
	end
	assign frame_magic   = ty_ff[0];
	assign frame_pattern = ty_ff[1];
	assign frame_bcast   = ty_ff[2];
	assign frame_ucast   = ty_ff[4];
	assign frame_crc_bad = ty_ff[6];
	assign frame_sfd_err = ty_ff[7];
endmodule

// *** sim/wolrc_tb_top.sv ***
// Testbench for the wake-on-network receive configuration block.
// Assumes wolrc_pkg, wolrc_top, wolrc_station and wolrc_chk are compiled first.
`timescale 1ns/10ps
module wolrc_tb_top;
	import wolrc_pkg::*;
	logic        clk, rst, reg_wr, reg_rd, req;
	logic [8:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [7:0]  req_ty;
	logic [47:0] req_pw, frame_password;
	logic        frame_done, frame_magic, frame_pattern, frame_bcast;
	logic        frame_ucast, frame_crc_bad, frame_sfd_err, wake_on_network, irq;
	int          fails, num_checks, cyc, n;

	wolrc_top wolrc_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_done(frame_done), .frame_magic(frame_magic), .frame_pattern(frame_pattern),
		.frame_bcast(frame_bcast), .frame_ucast(frame_ucast), .frame_crc_bad(frame_crc_bad),
		.frame_sfd_err(frame_sfd_err), .frame_password(frame_password),
		.wake_on_network(wake_on_network), .irq(irq));
	wolrc_station wolrc_station_inst (.clk(clk), .rst(rst), .req(req), .req_ty(req_ty),
		.req_pw(req_pw), .frame_done(frame_done), .frame_magic(frame_magic),
		.frame_pattern(frame_pattern), .frame_bcast(frame_bcast), .frame_ucast(frame_ucast),
		.frame_crc_bad(frame_crc_bad), .frame_sfd_err(frame_sfd_err),
		.frame_password(frame_password));

	initial clk = 1'b0;
	always #5 clk = ~clk;
	// Whole run needs under 500 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// With two set, a second back-to-back read must find the flags cleared
	task rd(input logic [8:0] a, input logic [15:0] e, input bit two);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		if (!two) reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		if (two) begin
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, 16'h0000);
		end
	endtask
	// Returns one ns after the edge that takes the report
	task frm(input logic [7:0] t, input logic [47:0] p);
		@(posedge clk);
		req    <= 1'b1;
		req_ty <= t;
		req_pw <= p;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, reg_wr, reg_rd, req, reg_addr, reg_wdata, req_ty, req_pw} = '0;
		rst = 1'b1;
		{fails, num_checks, cyc} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(WOLRC_CFG_IDX, 16'h0004, 0);
		wr(9'h1ff, 16'hffff);
		rd(9'h1ff, 16'h0000, 0);
		rd(WOLRC_CFG_IDX, 16'h0004, 0);
		wr(WOLRC_CFG_IDX, 16'h0017);
		frm(8'h17, 48'h0);
		chk(16'(wake_on_network), 16'h0000);
		rd(WOLRC_FLAGS_IDX, 16'h0000, 0);
		for (int i = 0; i < 5; i++) begin
			if (i != 3) begin
				wr(WOLRC_CFG_IDX, 16'h0080 | 16'(1 << i));
				frm(8'(1 << i), 48'h0);
				chk(16'(wake_on_network), 16'h0001);
				repeat (20) @(posedge clk);
				rd(WOLRC_FLAGS_IDX, 16'(1 << i), 1);
				wr(WOLRC_CFG_IDX, 16'h0080);
				frm(8'(1 << i), 48'h0);
				chk(16'(wake_on_network), 16'h0000);
				rd(WOLRC_FLAGS_IDX, 16'(1 << i), 0);
			end
		end
		// Lengths are 8 ns periods rounded up to whole 10 ns cycles
		for (int s = 0; s < 4; s++) begin
			wr(WOLRC_CFG_IDX, 16'h0081 | 16'(s << 9));
			frm(8'h01, 48'h0);
			n = 0;
			while (wake_on_network === 1'b1 && n < 100) begin
				n++;
				@(posedge clk);
				#1;
			end
			chk(16'(n), 16'((64 * (1 << s) + 9) / 10));
			rd(WOLRC_FLAGS_IDX, 16'h0001, 0);
		end
		wr(WOLRC_CFG_IDX, 16'h0190);
		frm(8'h10, 48'h0);
		repeat (80) @(posedge clk);
		#1 chk(16'(wake_on_network), 16'h0001);
		@(posedge clk);
		reg_addr  <= WOLRC_CFG_IDX;
		reg_wdata <= 16'h0990;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, 16'h0990);
		rd(WOLRC_CFG_IDX, 16'h0190, 0);
		chk(16'(wake_on_network), 16'h0000);
		rd(WOLRC_FLAGS_IDX, 16'h0010, 0);
		wr(WOLRC_PWD0_IDX, 16'h1111);
		wr(WOLRC_PWD1_IDX, 16'h2222);
		wr(WOLRC_PWD2_IDX, 16'h3333);
		wr(WOLRC_CFG_IDX, 16'h00a1);
		frm(8'h01, 48'h333322221111);
		chk(16'(wake_on_network), 16'h0001);
		repeat (20) @(posedge clk);
		rd(WOLRC_FLAGS_IDX, 16'h0001, 0);
		frm(8'h01, 48'h111122223333);
		chk(16'(wake_on_network), 16'h0000);
		rd(WOLRC_FLAGS_IDX, 16'h0020, 0);
		wr(WOLRC_CFG_IDX, 16'h0090);
		frm(8'h50, 48'h0);
		chk(16'(wake_on_network), 16'h0000);
		rd(WOLRC_FLAGS_IDX, 16'h0040, 0);
		frm(8'h90, 48'h0);
		rd(WOLRC_FLAGS_IDX, 16'h0080, 0);
		chk(16'(irq), 16'h0000);
		wr(WOLRC_IRQ_MASK_IDX, 16'h0008);
		#1 chk(16'(irq), 16'h0001);
		wr(WOLRC_IRQ_STS_IDX, 16'h00ff);
		#1 chk(16'(irq), 16'h0000);
		frm(8'h10, 48'h0);
		chk(16'(irq), 16'h0001);
		wr(WOLRC_IRQ_MASK_IDX, 16'h0000);
		#1 chk(16'(irq), 16'h0000);
		summarize();
	end
endmodule

bind wolrc_top wolrc_chk wolrc_chk_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.frame_done(frame_done), .frame_magic(frame_magic), .frame_pattern(frame_pattern),
	.frame_bcast(frame_bcast), .frame_ucast(frame_ucast), .frame_crc_bad(frame_crc_bad),
	.frame_sfd_err(frame_sfd_err), .wake_on_network(wake_on_network));
